// File: lrs_regs.svh
/*
 holds register offsets, field positions, reset values and timing counts
 of the link redundancy selector as macros.
 assumes inclusion by bare name from the selector and the bench files.
*/
`ifndef LRS_REGS_SVH
`define LRS_REGS_SVH

`define LRS_OFS_CTRL        12'h000
`define LRS_OFS_STATUS      12'h004
`define LRS_OFS_IRQ_STAT    12'h008
`define LRS_OFS_IRQ_MASK    12'h00C
`define LRS_OFS_REMOTE      12'h010

`define LRS_CTRL_MODE_LSB   0
`define LRS_CTRL_RESET      2'h0
`define LRS_MODE_OFF        2'h0
`define LRS_MODE_AUTO       2'h1
`define LRS_MODE_MANUAL     2'h2

`define LRS_IRQ_SWITCH      0
`define LRS_IRQ_MODE_DONE   1
`define LRS_IRQ_BOTH_FAIL   2
`define LRS_IRQ_BITS        3

`define LRS_CLK_MHZ         200
`define LRS_APPLY_SEC       120
`define LRS_FLASH_MS        250
`define LRS_FLASH_CYC       (`LRS_FLASH_MS * `LRS_CLK_MHZ * 1000)
`define LRS_APPLY_CYC       (64'd`LRS_APPLY_SEC * 64'd`LRS_CLK_MHZ * 64'd1000000)

`endif

// File: lrs_pkg.sv
/*
 holds the types of the link redundancy selector.
 assumes lrs_regs.svh sits in the same folder.
*/
package lrs_pkg;
  typedef enum logic [1:0] {LRS_OFF, LRS_AUTO, LRS_MANUAL, LRS_BAD} lrs_mode_t;
  typedef enum logic {LRS_MAIN, LRS_BACKUP} lrs_link_t;
  typedef enum logic {LRS_CAUSE_SIG, LRS_CAUSE_SYNC} lrs_cause_t;
endpackage

// File: lrs_flash.sv
/*
 holds a free running blink generator for the indicators.
 assumes a single clock and a synchronous active low reset.
*/
`timescale 1ns/100ps
module lrs_flash #(
  parameter int HALF_CYC = 50000000
) (
  input  wire logic aclk,    // system clock
  input  wire logic aresetn, // sync reset, low active
  input  wire logic ce,      // clock enable
  output logic      blink_q  // square wave
);
  logic [31:0] cnt_q;

  // refuse a half period the counter cannot serve
  if (HALF_CYC < 1)
  begin : g_bad_half
    $error("lrs_flash: HALF_CYC must be at least one");
  end

  // toggles every half period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q   <= 32'h0000_0000;
      blink_q <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt_q >= 32'(HALF_CYC - 1))
      begin
        cnt_q   <= 32'h0000_0000;
        blink_q <= ~blink_q;
      end
      else
        cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
endmodule

// File: lrs_selector.sv
/*
 holds the link redundancy selector: axi4-lite registers, link choice,
 indicators, remote forwarding of mode and interrupt.
 assumes synchronous inputs from both receivers and a single 200 MHz clock.
*/
// Function
// RL1: automatic mode with both modules installed starts on the main link.
// RL2: automatic or manual mode switches to backup on main signal or sync loss.
// RL3: sync-loss indicator of the deactivated link is lit; the code lights backup's only in auto or manual mode with backup fitted.
// RL4: automatic, signal-loss switchover returns to main when signal returns.
// RL5: automatic, sync-loss switchover stays on backup until backup fails; the code also returns to main when automatic mode is applied again.
// RL6: manual mode starts on main and stays on backup after main recovers.
// RL7: manual returns to main only on change to automatic or power cycle.
// RL8: mode off performs no automatic switching.
// RL9: per-link received-signal indicator lit while that receiver sees signal.
// RL10: local mode changes are forwarded to the remote unit.
// RL11: operator gives both units one mode; only one uses loopback timing.
// RL12: mode changes take effect within 120 seconds.
// RL13: main sync-loss indicator flashes while traffic comes from backup.
// RL14: active link and last cause held in registers, reset to main.
`timescale 1ns/100ps
`include "lrs_regs.svh"
module lrs_selector #(
  parameter longint APPLY_CYC = `LRS_APPLY_CYC,
  parameter int     FLASH_CYC = `LRS_FLASH_CYC
) (
  input  wire logic        aclk,            // system clock
  input  wire logic        aresetn,         // sync reset, low active
  input  wire logic        ce,              // clock enable
  input  wire logic [11:0] s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // byte enables
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [11:0] s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire logic        main_present,    // main module fitted
  input  wire logic        backup_present,  // backup module fitted
  input  wire logic        main_sig_loss,   // main receiver signal loss
  input  wire logic        main_sync_loss,  // main receiver sync loss
  input  wire logic        backup_sig_loss, // backup receiver signal loss
  input  wire logic        backup_sync_loss,// backup receiver sync loss
  output logic             use_backup_q,    // high: traffic on backup
  output logic             main_rx_led_q,   // main signal detected
  output logic             backup_rx_led_q, // backup signal detected
  output logic             main_loss_led_q, // main sync-loss indicator
  output logic             backup_loss_led_q,// backup sync-loss indicator
  output logic [1:0]       remote_mode_q,   // mode sent to remote unit
  output logic             remote_send_q,   // pulse: send mode to remote
  output logic             irq_q            // level interrupt
);
  localparam int IW = `LRS_IRQ_BITS;

  logic [1:0]     req_mode_q;   // mode software wrote
  logic [1:0]     mode_q;       // mode in force
  logic [63:0]    apply_cnt_q;
  logic           apply_pend_q;
  logic           cause_q;      // last switchover cause
  logic [IW-1:0]  istat_q, imask_q;
  logic           aw_got_q, w_got_q;
  logic [11:0]    awaddr_q;
  logic [31:0]    wdata_q;
  logic           blink;

  // refuse counts the apply and flash counters cannot serve
  if (APPLY_CYC < 1 || FLASH_CYC < 1)
  begin : g_bad_counts
    $error("lrs_selector: counts must be at least one");
  end

  lrs_flash #(.HALF_CYC(FLASH_CYC)) u_flash (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .blink_q (blink)
  );

  // address decode shared by both paths
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `LRS_OFS_CTRL) || (a == `LRS_OFS_STATUS) || (a == `LRS_OFS_IRQ_STAT)
           || (a == `LRS_OFS_IRQ_MASK) || (a == `LRS_OFS_REMOTE);
  endfunction

  // write handshake: address and data taken in either order
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        aw_have = aw_got_q | aw_take;
  wire        w_have  = w_got_q | w_take;
  wire [11:0] wa      = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd      = w_got_q ? wdata_q : s_axi_wdata;
  wire        wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire        wr_ctrl = wr_go & (wa == `LRS_OFS_CTRL) & s_axi_wstrb[0];
  wire        wr_clr  = wr_go & (wa == `LRS_OFS_IRQ_STAT) & s_axi_wstrb[0];
  wire        wr_mask = wr_go & (wa == `LRS_OFS_IRQ_MASK) & s_axi_wstrb[0];
  wire [1:0]  wr_mode = wd[`LRS_CTRL_MODE_LSB +: 2];
  wire        mode_ok = (wr_mode != 2'h3);

  // link health and selection decisions
  wire main_bad   = main_sig_loss | main_sync_loss;
  wire backup_bad = backup_sig_loss | backup_sync_loss | ~backup_present;
  wire redund     = (mode_q == `LRS_MODE_AUTO) || (mode_q == `LRS_MODE_MANUAL);
  wire go_backup  = ~use_backup_q & redund & main_bad & ~backup_bad;        // RL2 RL8
  wire auto_back  = use_backup_q & (mode_q == `LRS_MODE_AUTO) & main_present
                  & ((cause_q == lrs_pkg::LRS_CAUSE_SIG & ~main_bad)         // RL4
                  | (cause_q == lrs_pkg::LRS_CAUSE_SYNC & backup_bad & ~main_bad)); // RL5
  wire apply_now  = apply_pend_q & (apply_cnt_q == 64'h0);
  wire to_auto    = apply_now & (req_mode_q == `LRS_MODE_AUTO);              // RL7
  wire go_main    = auto_back | (use_backup_q & to_auto & ~main_bad);
  wire both_bad   = ~use_backup_q & redund & main_bad & backup_bad;          // nowhere left to go
  wire [IW-1:0] ev = {both_bad, apply_now, go_backup | go_main};

  // axi handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (ce)
    begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata;
      aw_got_q <= aw_have & ~wr_go;
      w_got_q  <= w_have & ~wr_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(wa) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // ready is taken away while a word is already held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else if (ce)
    begin
      s_axi_awready <= ~(aw_have & ~wr_go) & ~(wr_go);
      s_axi_wready  <= ~(w_have & ~wr_go) & ~(wr_go);
    end
  end

  // read channel, one word per request
  wire [31:0] rd_word =
      (s_axi_araddr == `LRS_OFS_CTRL)     ? {30'h0, req_mode_q} :
      (s_axi_araddr == `LRS_OFS_STATUS)   ? {24'h0, apply_pend_q, mode_q, cause_q,
                                             backup_present, main_present, use_backup_q, 1'b0} :
      (s_axi_araddr == `LRS_OFS_IRQ_STAT) ? {29'h0, istat_q} :
      (s_axi_araddr == `LRS_OFS_IRQ_MASK) ? {29'h0, imask_q} :
      (s_axi_araddr == `LRS_OFS_REMOTE)   ? {30'h0, remote_mode_q} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= reg_hit(s_axi_araddr) ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // mode request, delayed apply and remote forwarding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_mode_q    <= `LRS_CTRL_RESET;
      mode_q        <= `LRS_CTRL_RESET;
      apply_pend_q  <= 1'b0;
      apply_cnt_q   <= 64'h0;
      remote_mode_q <= `LRS_CTRL_RESET;
      remote_send_q <= 1'b0;
    end
    else if (ce)
    begin
      remote_send_q <= 1'b0;
      if (wr_ctrl & mode_ok)
      begin
        req_mode_q    <= wr_mode;
        apply_pend_q  <= 1'b1;
        // the settle runs the whole APPLY_CYC count, giving the remote time to follow, right at the limit
        apply_cnt_q   <= 64'(APPLY_CYC - 1);                                 // RL12
        remote_mode_q <= wr_mode;                                           // RL10
        remote_send_q <= 1'b1;                                              // RL10
      end
      else if (apply_now)
      begin
        mode_q       <= req_mode_q;                                         // RL12
        apply_pend_q <= 1'b0;
      end
      else if (apply_pend_q) apply_cnt_q <= apply_cnt_q - 64'h1;
    end
  end

  // active link and cause; reset is the power cycle that returns to main
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      use_backup_q <= 1'b0;                                                 // RL1 RL6 RL14
      cause_q      <= 1'b0;                                                 // RL14
    end
    else if (ce)
    begin
      if (go_backup)
      begin
        use_backup_q <= 1'b1;                                               // RL2
        cause_q      <= main_sig_loss ? 1'b0 : 1'b1;
      end
      else if (go_main) use_backup_q <= 1'b0;                               // RL4 RL7
    end
  end

  // indicators
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_rx_led_q     <= 1'b0;
      backup_rx_led_q   <= 1'b0;
      main_loss_led_q   <= 1'b0;
      backup_loss_led_q <= 1'b0;
    end
    else if (ce)
    begin
      main_rx_led_q     <= main_present & ~main_sig_loss;                   // RL9
      backup_rx_led_q   <= backup_present & ~backup_sig_loss;               // RL9
      main_loss_led_q   <= use_backup_q ? blink : main_bad;                 // RL3 RL13
      backup_loss_led_q <= ~use_backup_q & backup_present & redund;         // RL3
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
    end
    else if (ce)
    begin
      istat_q <= (istat_q & ~(wr_clr ? wd[IW-1:0] : '0)) | ev;
      if (wr_mask) imask_q <= wd[IW-1:0];
      irq_q <= |(istat_q & imask_q);
    end
  end

  chk_main_fail_switch: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    ce && go_backup |=> use_backup_q) else $error("no switch to backup");
  chk_off_no_switch: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    ce && mode_q == `LRS_MODE_OFF && !use_backup_q |=> !use_backup_q) else $error("switched in off");
  chk_manual_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    ce && use_backup_q && mode_q == `LRS_MODE_MANUAL && !to_auto |=> use_backup_q)
    else $error("manual left backup");
  chk_sig_return: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    ce && auto_back && cause_q == 1'b0 |=> !use_backup_q) else $error("no return");
  chk_rx_led: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    ce && main_present && !main_sig_loss |=> main_rx_led_q) else $error("rx led off");
  chk_remote_fwd: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    ce && wr_ctrl && mode_ok |=> remote_send_q && remote_mode_q == $past(wr_mode))
    else $error("mode not forwarded");
  chk_backup_led: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    ce && !use_backup_q && backup_present && redund |=> backup_loss_led_q) else $error("led wrong");
  chk_apply_bound: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
    apply_pend_q |-> apply_cnt_q < 64'(APPLY_CYC)) else $error("apply late");
  chk_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    ce && use_backup_q && mode_q == `LRS_MODE_AUTO && cause_q == 1'b1 && !backup_bad && !apply_now
    |=> use_backup_q) else $error("sync cause left backup");
  chk_main_led_flash: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    ce && use_backup_q |=> main_loss_led_q == $past(blink)) else $error("main led not flashing");
  chk_main_led_loss: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    ce && !use_backup_q |=> main_loss_led_q == $past(main_bad)) else $error("main led wrong");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> irq_q == |($past(istat_q) & $past(imask_q))) else $error("irq level wrong");
  chk_irq_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev[`LRS_IRQ_SWITCH] |=> istat_q[`LRS_IRQ_SWITCH]) else $error("switch event lost");
endmodule

// File: lrs_link_model.sv
/*
 holds a behavioural model of one optical link receiver module.
 assumes the bench drives its fault commands just after a rising edge.
*/
`timescale 1ns/100ps
module lrs_link_model (
  input  wire logic aclk,      // system clock
  input  wire logic fail_sig,  // command: drop the light
  input  wire logic fail_sync, // command: lose framing
  output logic      sig_loss,  // signal-loss alarm
  output logic      sync_loss  // sync-loss alarm
);
  // alarms lag the line by one clock; no filtering, so short
  // faults reach the selector just as a bare receiver would pass them
  always_ff @(posedge aclk)
  begin
    sig_loss  <= fail_sig;
    sync_loss <= fail_sync;
  end
endmodule

// File: link_redundancy_selector_tb_top.sv
/*
 holds the self-checking bench of the link redundancy selector.
 assumes lrs_regs.svh, lrs_pkg.sv, lrs_flash.sv, lrs_selector.sv, lrs_link_model.sv.
*/
`timescale 1ns/100ps
`include "lrs_regs.svh"
module link_redundancy_selector_tb_top;
  localparam longint APPLY = 20;
  localparam int     FLASH = 4;
  logic        aclk, aresetn, ce, main_present, backup_present;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, remote_mode_q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        main_sig_loss, main_sync_loss, backup_sig_loss, backup_sync_loss;
  logic        use_backup_q, main_rx_led_q, backup_rx_led_q, main_loss_led_q, backup_loss_led_q;
  logic        remote_send_q, irq_q;
  logic        m_fsig, m_fsync, b_fsig, b_fsync, hi, lo;
  logic [31:0] seed = 32'h000144BD;
  logic [31:0] d;
  logic [1:0]  r;
  int          err_count = 0;
  int          samples_checked = 0;
  int          sends = 0;
  int          sends_seen = 0;

  lrs_selector #(.APPLY_CYC(APPLY), .FLASH_CYC(FLASH)) uut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .main_present, .backup_present, .main_sig_loss, .main_sync_loss, .backup_sig_loss,
    .backup_sync_loss, .use_backup_q, .main_rx_led_q, .backup_rx_led_q, .main_loss_led_q,
    .backup_loss_led_q, .remote_mode_q, .remote_send_q, .irq_q);
  lrs_link_model m_rx (.aclk, .fail_sig(m_fsig), .fail_sync(m_fsync),
    .sig_loss(main_sig_loss), .sync_loss(main_sync_loss));
  lrs_link_model b_rx (.aclk, .fail_sig(b_fsig), .fail_sync(b_fsync),
    .sig_loss(backup_sig_loss), .sync_loss(backup_sync_loss));

  // clock generator
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // xorshift so random waits and payload bits repeat run to run
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected STATUS bits, cause and pending masked off
  function automatic logic [31:0] st_exp(input logic [1:0] m, input logic bk);
    return {25'h0, m, 1'b0, 1'b1, 1'b1, bk, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        aw = 1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1;
      end
    end while (!(aw && w));
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // mode write with random upper bits, then wait out the apply delay
  task automatic set_mode(input logic [1:0] m, input logic bk);
    logic [31:0] v;
    int          s0;
    v = nxt();
    v[1:0] = m;
    s0 = sends;
    wr(`LRS_OFS_CTRL, v, r);
    chk({30'h0, r}, 32'h0);
    repeat (APPLY + 5) @(posedge aclk);
    chk({30'h0, remote_mode_q}, {30'h0, m});
    chk(32'(sends - s0), 32'h1);
    rd(`LRS_OFS_STATUS, d, r);
    chk(d & 32'h0000006E, st_exp(m, bk));
  endtask

  // apply receiver faults {msig,msync,bsig,bsync}, then check the choice
  task automatic fault(input logic [3:0] f, input logic expb);
    {m_fsig, m_fsync, b_fsig, b_fsync} <= f;
    repeat (4 + nxt() % 4) @(posedge aclk);
    chk({31'h0, use_backup_q}, {31'h0, expb});
  endtask

  // counts forwarding pulses as the remote unit would see them
  always @(posedge aclk)
  begin
    if (remote_send_q === 1'b1) sends <= sends + 1;
  end

  // watchdog sized well past the whole sequence
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end

  initial
  begin
    aresetn = 1'b0; ce = 1'b1; main_present = 1'b1; backup_present = 1'b1;
    {m_fsig, m_fsync, b_fsig, b_fsync} = 4'h0;
    s_axi_awaddr = 12'h000; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 12'h000; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, use_backup_q}, 32'h0);
    set_mode(`LRS_MODE_AUTO, 1'b0);
    chk({31'h0, use_backup_q}, 32'h0);
    chk({30'h0, backup_loss_led_q, main_rx_led_q}, 32'h3);
    wr(`LRS_OFS_IRQ_MASK, 32'h00000001, r);
    fault(4'h8, 1'b1);
    chk({30'h0, main_rx_led_q, backup_rx_led_q}, 32'h1);
    rd(`LRS_OFS_STATUS, d, r);
    chk({31'h0, d[4]}, 32'h0);
    hi = 0;
    lo = 0;
    repeat (4 * FLASH)
    begin
      @(posedge aclk);
      if (main_loss_led_q === 1'b1) hi = 1;
      if (main_loss_led_q === 1'b0) lo = 1;
    end
    chk({30'h0, hi, lo}, 32'h3);
    chk({31'h0, irq_q}, 32'h1);
    rd(`LRS_OFS_IRQ_STAT, d, r);
    chk(d & 32'h1, 32'h1);
    wr(`LRS_OFS_IRQ_STAT, 32'h00000007, r);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    fault(4'h0, 1'b0);
    fault(4'h4, 1'b1);
    rd(`LRS_OFS_STATUS, d, r);
    chk({31'h0, d[4]}, 32'h1);
    fault(4'h0, 1'b1);
    fault(4'h1, 1'b0);
    fault(4'h0, 1'b0);
    fault(4'hA, 1'b0);
    rd(`LRS_OFS_IRQ_STAT, d, r);
    chk(d & 32'h00000006, 32'h00000004);
    fault(4'h0, 1'b0);
    set_mode(`LRS_MODE_MANUAL, 1'b0);
    @(posedge aclk);
    rd(`LRS_OFS_IRQ_STAT, d, r);
    chk(d, 32'h00000007);
    fault(4'h8, 1'b1);
    fault(4'h0, 1'b1);
    set_mode(`LRS_MODE_AUTO, 1'b0);
    chk({31'h0, use_backup_q}, 32'h0);
    ce <= 1'b0;
    fault(4'h8, 1'b0);
    ce <= 1'b1;
    fault(4'h8, 1'b1);
    fault(4'h0, 1'b0);
    sends_seen = sends;
    wr(`LRS_OFS_CTRL, 32'h00000003, r);
    chk({30'h0, r}, 32'h0);
    repeat (APPLY + 5) @(posedge aclk);
    chk({30'h0, remote_mode_q}, 32'h1);
    chk(32'(sends - sends_seen), 32'h0);
    set_mode(`LRS_MODE_MANUAL, 1'b0);
    fault(4'h8, 1'b1);
    fault(4'h0, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, use_backup_q}, 32'h0);
    rd(`LRS_OFS_STATUS, d, r);
    chk(d & 32'h0000006E, st_exp(`LRS_MODE_OFF, 1'b0));
    set_mode(`LRS_MODE_OFF, 1'b0);
    fault(4'h8, 1'b0);
    fault(4'h4, 1'b0);
    fault(4'h0, 1'b0);
    rd(12'h020, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(12'h020, nxt(), r);
    chk({30'h0, r}, 32'h2);
    close_out();
  end
endmodule
